// ==== rtl/mmd_pkg.sv ====
// Shared constants and types of the memory map decoder.
package mmd_pkg;

  typedef enum logic [2:0] {
    VAR_ROMLESS = 3'b000,
    VAR_ROM48K = 3'b001,
    VAR_ROM32K = 3'b010,
    VAR_ROM24K = 3'b011,
    VAR_OTP48K = 3'b100
  } mmd_variant_t;

  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_ROM = 3'b001,
    TGT_EXT = 3'b010,
    TGT_PRAM = 3'b011,
    TGT_MRAM = 3'b100,
    TGT_SFR = 3'b101
  } mmd_target_t;

  typedef enum logic [1:0] {
    KIND_ACCESS = 2'b00,
    KIND_VECTOR = 2'b01,
    KIND_TCALL = 2'b10,
    KIND_FCALL = 2'b11
  } mmd_kind_t;

  localparam logic [15:0] ROM48_TOP = 16'hbfff;
  localparam logic [15:0] ROM32_TOP = 16'h7fff;
  localparam logic [15:0] ROM24_TOP = 16'h5fff;
  localparam logic [15:0] PRAM_LO = 16'hf700;
  localparam logic [15:0] PRAM24_LO = 16'hfc00;
  localparam logic [15:0] PRAM_HI = 16'hfdff;
  localparam logic [15:0] MRAM_LO = 16'hfe00;
  localparam logic [15:0] MRAM_HI = 16'hfeff;
  localparam logic [15:0] MACRO_LO = 16'hfe06;
  localparam logic [15:0] MACRO_HI = 16'hfe25;
  localparam logic [15:0] GPR_LO = 16'hfe80;
  localparam logic [15:0] SFR_LO = 16'hff00;
  localparam logic [15:0] SFR_HI = 16'hffff;
  localparam logic [15:0] XACC_LO = 16'hffd0;
  localparam logic [15:0] XACC_HI = 16'hffdf;
  localparam logic [15:0] TCALL_BASE = 16'h0040;
  localparam logic [15:0] FCALL_BASE = 16'h0800;
  localparam logic [15:0] RELOC_OFS = 16'h8000;
  localparam logic [15:0] WRAP_LO_OFS = 16'h00ff;
  localparam logic [15:0] WRAP_HI_OFS = 16'h0100;
  localparam logic [15:0] ONE_ADDR = 16'h0001;
  localparam logic [15:0] ZERO_ADDR = 16'h0000;
  localparam logic [4:0] RESET_VEC_IDX = 5'h00;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

endpackage

// ==== rtl/mmd_sync2.sv ====
// Two flip-flop synchroniser for a level from a pin.
`timescale 1ns/1ns
module mmd_sync2 (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Level in and out
  input wire logic i_level,
  output logic o_level
);
  logic stage1;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      stage1 <= 1'b0;
      o_level <= 1'b0;
    end else begin
      stage1 <= i_level;
      o_level <= stage1;
    end
  end
endmodule

// ==== rtl/mmd_range.sv ====
// Inclusive address range comparator.
`timescale 1ns/1ns
module mmd_range #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hffff
) (
  // Address in, hit out
  input wire logic [15:0] i_addr,
  output logic o_hit
);
  assign o_hit = (i_addr >= LO) && (i_addr <= HI);
endmodule

// ==== rtl/mmd_decoder.sv ====
// Memory map decoder with vector, table-call and word-pairing logic.
`timescale 1ns/1ns
module mmd_decoder
  import mmd_pkg::*;
#(
  parameter mmd_variant_t VARIANT = VAR_ROM32K
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // Mode pins and control word flag
  input wire logic I_MODE_SELECT_PIN_A,
  input wire logic I_MODE_SELECT_PIN_B,
  input wire logic I_TABLE_RELOCATE_FLAG,
  // Request from the core
  input wire logic I_REQ,
  input wire mmd_kind_t I_KIND,
  input wire logic [15:0] I_ADDR,
  input wire logic [10:0] I_INDEX,
  input wire logic I_WORD,
  input wire logic I_WRITE,
  input wire logic I_FETCH,
  // Read data returned for a vector or table entry
  input wire logic I_RVALID,
  input wire logic [7:0] I_RDATA_LO,
  input wire logic [7:0] I_RDATA_HI,
  // Mode status
  output logic O_READY,
  output logic O_ROMLESS,
  output logic O_PROG_MODE,
  output logic O_MODE_ERR,
  // Decoded access
  output logic O_ACK,
  output mmd_target_t O_TARGET,
  output logic [15:0] O_LO_ADDR,
  output logic [15:0] O_HI_ADDR,
  output logic O_WORD,
  output logic O_WRITE,
  output logic O_FETCH,
  output logic O_EXT_REQ,
  output logic O_FAST,
  output logic O_MACRO_AREA,
  output logic O_GPR_AREA,
  output logic [2:0] O_GPR_BANK,
  // Program counter load
  output logic O_PC_LOAD,
  output logic [15:0] O_PC
);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } mmd_state_t;

  mmd_state_t state;
  mmd_state_t next_state;
  logic mode_a;
  logic mode_b;
  logic settled;
  logic [1:0] settle_cnt;
  logic take;
  logic reloc;
  logic word_eff;
  logic [15:0] eff;
  logic [15:0] rom_top;
  logic [15:0] next_lo;
  logic [15:0] next_hi;
  mmd_target_t next_tgt;
  logic hit_sfr;
  logic hit_xacc;
  logic hit_main;
  logic hit_pram;
  logic hit_pram24;
  logic hit_macro;
  logic hit_gpr;

  mmd_sync2 u_sync_a (
    .i_clk(I_REF_CLK),
    .i_rstn(I_RSTN),
    .i_level(I_MODE_SELECT_PIN_A),
    .o_level(mode_a)
  );

  mmd_sync2 u_sync_b (
    .i_clk(I_REF_CLK),
    .i_rstn(I_RSTN),
    .i_level(I_MODE_SELECT_PIN_B),
    .o_level(mode_b)
  );

  // The mode pins are static; they are caught once the synchronisers settle.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      settle_cnt <= 2'h0;
      settled <= 1'b0;
      O_ROMLESS <= 1'b0;
      O_PROG_MODE <= 1'b0;
      O_MODE_ERR <= 1'b0;
    end else if (!settled) begin
      settle_cnt <= settle_cnt + 2'h1;
      if (settle_cnt == SETTLE_CYCLES) begin
        settled <= 1'b1;
        O_ROMLESS <= (VARIANT == VAR_ROMLESS) ||
          (mode_a && mode_b && (VARIANT != VAR_OTP48K));
        O_PROG_MODE <= (VARIANT == VAR_OTP48K) && mode_a && !mode_b;
        O_MODE_ERR <= (!mode_a && mode_b) ||
          ((VARIANT == VAR_ROMLESS) && !(mode_a && mode_b)) ||
          ((VARIANT == VAR_OTP48K) && mode_a && mode_b) ||
          ((VARIANT != VAR_OTP48K) && mode_a && !mode_b);
      end
    end
  end

  assign take = I_REQ && O_READY;

  // Effective address of the request within the 16-bit space.
  always_comb begin
    eff = I_ADDR;
    reloc = 1'b0;
    unique case (I_KIND)
      KIND_ACCESS: begin
        eff = I_ADDR;
      end
      KIND_VECTOR: begin
        eff = {10'h000, I_INDEX[4:0], 1'b0};
        reloc = I_TABLE_RELOCATE_FLAG &&
          (I_INDEX[4:0] != RESET_VEC_IDX);
      end
      KIND_TCALL: begin
        eff = TCALL_BASE | {10'h000, I_INDEX[4:0], 1'b0};
        reloc = I_TABLE_RELOCATE_FLAG;
      end
      KIND_FCALL: begin
        eff = FCALL_BASE | {5'h00, I_INDEX[10:0]};
      end
    endcase
    if (reloc) begin
      eff = eff | RELOC_OFS;
    end
  end

  mmd_range #(.LO(SFR_LO), .HI(SFR_HI)) u_r_sfr (
    .i_addr(eff),
    .o_hit(hit_sfr)
  );
  mmd_range #(.LO(XACC_LO), .HI(XACC_HI)) u_r_xacc (
    .i_addr(eff),
    .o_hit(hit_xacc)
  );
  mmd_range #(.LO(MRAM_LO), .HI(MRAM_HI)) u_r_main (
    .i_addr(eff),
    .o_hit(hit_main)
  );
  mmd_range #(.LO(PRAM_LO), .HI(PRAM_HI)) u_r_pram (
    .i_addr(eff),
    .o_hit(hit_pram)
  );
  mmd_range #(.LO(PRAM24_LO), .HI(PRAM_HI)) u_r_pram24 (
    .i_addr(eff),
    .o_hit(hit_pram24)
  );
  mmd_range #(.LO(MACRO_LO), .HI(MACRO_HI)) u_r_macro (
    .i_addr(eff),
    .o_hit(hit_macro)
  );
  mmd_range #(.LO(GPR_LO), .HI(MRAM_HI)) u_r_gpr (
    .i_addr(eff),
    .o_hit(hit_gpr)
  );

  always_comb begin
    unique case (VARIANT)
      VAR_ROM48K, VAR_OTP48K: rom_top = ROM48_TOP;
      VAR_ROM32K: rom_top = ROM32_TOP;
      VAR_ROM24K: rom_top = ROM24_TOP;
      VAR_ROMLESS: rom_top = ZERO_ADDR;
    endcase
  end

  // Region selection; relocated tables always live off chip.
  always_comb begin
    if (reloc || hit_xacc) begin
      next_tgt = TGT_EXT;
    end else if (hit_sfr) begin
      next_tgt = TGT_SFR;
    end else if (hit_main) begin
      next_tgt = TGT_MRAM;
    end else if (hit_pram && (VARIANT != VAR_ROM24K || hit_pram24)) begin
      next_tgt = TGT_PRAM;
    end else if (!O_ROMLESS && (eff <= rom_top)) begin
      next_tgt = TGT_ROM;
    end else begin
      next_tgt = TGT_EXT;
    end
  end

  // Byte pairing of word accesses.
  always_comb begin
    word_eff = I_WORD || (I_KIND == KIND_VECTOR) || (I_KIND == KIND_TCALL);
    next_lo = eff;
    next_hi = eff;
    if (word_eff) begin
      next_hi = eff + ONE_ADDR;
      if (next_tgt == TGT_MRAM && eff[0]) begin
        next_lo = eff - ONE_ADDR;
        next_hi = eff;
      end else if (next_tgt == TGT_PRAM && eff == PRAM_HI) begin
        next_lo = eff + WRAP_LO_OFS;
        next_hi = eff + WRAP_HI_OFS;
      end
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (take && (I_KIND == KIND_VECTOR || I_KIND == KIND_TCALL)) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (I_RVALID) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      state <= ST_IDLE;
      O_READY <= 1'b0;
    end else begin
      state <= next_state;
      O_READY <= settled && !O_PROG_MODE && (next_state == ST_IDLE);
    end
  end

  // Decoded access outputs.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      O_ACK <= 1'b0;
      O_TARGET <= TGT_NONE;
      O_LO_ADDR <= ZERO_ADDR;
      O_HI_ADDR <= ZERO_ADDR;
      O_WORD <= 1'b0;
      O_WRITE <= 1'b0;
      O_FETCH <= 1'b0;
      O_EXT_REQ <= 1'b0;
      O_FAST <= 1'b0;
      O_MACRO_AREA <= 1'b0;
      O_GPR_AREA <= 1'b0;
      O_GPR_BANK <= 3'h0;
    end else begin
      O_ACK <= take && (I_KIND != KIND_FCALL);
      O_EXT_REQ <= take && (I_KIND != KIND_FCALL) &&
        (next_tgt == TGT_EXT);
      if (take && I_KIND != KIND_FCALL) begin
        O_TARGET <= next_tgt;
        O_LO_ADDR <= next_lo;
        O_HI_ADDR <= next_hi;
        O_WORD <= word_eff;
        O_WRITE <= I_WRITE && (I_KIND == KIND_ACCESS);
        O_FETCH <= I_FETCH || (I_KIND != KIND_ACCESS);
        O_FAST <= (next_tgt == TGT_MRAM);
        O_MACRO_AREA <= hit_macro && !reloc;
        O_GPR_AREA <= hit_gpr && !reloc;
        O_GPR_BANK <= eff[6:4];
      end
    end
  end

  // Program counter loads from a returned entry or a fixed-area call.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      O_PC_LOAD <= 1'b0;
      O_PC <= ZERO_ADDR;
    end else begin
      O_PC_LOAD <= 1'b0;
      if (state == ST_WAIT && I_RVALID) begin
        O_PC_LOAD <= 1'b1;
        O_PC <= {I_RDATA_HI, I_RDATA_LO};
      end else if (take && I_KIND == KIND_FCALL) begin
        O_PC_LOAD <= 1'b1;
        O_PC <= eff;
      end
    end
  end

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RSTN);

  sequence s_take_vec;
    take && I_KIND == KIND_VECTOR;
  endsequence

  sequence s_take_acc;
    take && I_KIND == KIND_ACCESS;
  endsequence

  reloc_vector_ext_a: assert property (
    s_take_vec and (I_TABLE_RELOCATE_FLAG && I_INDEX[4:0] != 5'h00)
    |=> O_TARGET == TGT_EXT && O_LO_ADDR[15] && O_EXT_REQ)
    else $error("relocated vector not sent external");

  reset_vector_a: assert property (
    s_take_vec and (I_INDEX[4:0] == 5'h00)
    |=> O_LO_ADDR == 16'h0000 && O_HI_ADDR == 16'h0001)
    else $error("reset vector address wrong");

  vector_wait_a: assert property (
    s_take_vec |=> !O_READY ##0 (state == ST_WAIT))
    else $error("vector fetch did not wait for data");

  pc_byte_order_a: assert property (
    state == ST_WAIT && I_RVALID
    |=> O_PC_LOAD && O_PC == {$past(I_RDATA_HI), $past(I_RDATA_LO)})
    else $error("vector bytes placed wrongly in PC");

  fcall_range_a: assert property (
    take && I_KIND == KIND_FCALL
    |=> O_PC_LOAD && O_PC[15:11] == 5'h01 && !O_ACK)
    else $error("fixed call outside its area");

  main_odd_pair_a: assert property (
    s_take_acc and (I_WORD && I_ADDR[15:8] == 8'hfe && I_ADDR[0])
    |=> O_LO_ADDR == $past(I_ADDR) - 16'h0001 && O_HI_ADDR == $past(I_ADDR))
    else $error("odd main RAM word pair wrong");

  pram_wrap_a: assert property (
    s_take_acc and (I_WORD && I_ADDR == 16'hfdff)
    |=> O_TARGET == TGT_PRAM && O_LO_ADDR == 16'hfefe &&
      O_HI_ADDR == 16'hfeff)
    else $error("peripheral RAM end word crossed");

  pram_pair_a: assert property (
    O_ACK && O_WORD && O_TARGET == TGT_PRAM && O_LO_ADDR != 16'hfefe
    |-> O_HI_ADDR == O_LO_ADDR + 16'h0001)
    else $error("peripheral RAM word pair wrong");

  ext_strobe_a: assert property (
    O_ACK |-> O_EXT_REQ == (O_TARGET == TGT_EXT))
    else $error("external strobe disagrees with target");

  sfr_area_a: assert property (
    s_take_acc and (I_ADDR[15:8] == 8'hff && I_ADDR[7:4] != 4'hd)
    |=> O_TARGET == TGT_SFR)
    else $error("special register area misdecoded");

  rom_decode_a: assert property (
    s_take_acc and (!O_ROMLESS && I_ADDR <= rom_top)
    |=> O_TARGET == TGT_ROM && !O_EXT_REQ)
    else $error("internal ROM address misdecoded");

endmodule

// ==== tb/mmd_core_model.sv ====
// Behavioural model of the core path that returns vector and table bytes.
`timescale 1ns/1ns
module mmd_core_model (
  // Clock
  input wire logic i_clk,
  // Decoder status and response delay
  input wire logic i_ack,
  input wire logic i_ready,
  input wire logic [15:0] i_lo_addr,
  input wire logic [15:0] i_hi_addr,
  input wire logic [3:0] i_delay,
  // Entry data
  output logic o_rvalid,
  output logic [7:0] o_rdata_lo,
  output logic [7:0] o_rdata_hi
);
  function automatic logic [7:0] dat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  initial begin
    o_rvalid = 1'b0;
    o_rdata_lo = 8'h00;
    o_rdata_hi = 8'h00;
  end

  // An acknowledge with ready low means an entry read is pending.
  always @(posedge i_clk) begin
    #1;
    if (i_ack === 1'b1 && i_ready === 1'b0) begin
      repeat (i_delay) @(posedge i_clk);
      #1;
      o_rvalid = 1'b1;
      o_rdata_lo = dat(i_lo_addr);
      o_rdata_hi = dat(i_hi_addr);
      @(posedge i_clk);
      #1;
      // Released data lines show the inverse so stale bytes never match.
      o_rvalid = 1'b0;
      o_rdata_lo = ~o_rdata_lo;
      o_rdata_hi = ~o_rdata_hi;
    end
  end
endmodule

// ==== tb/mmd_decoder_tb_top.sv ====
// Self-checking testbench of the memory map decoder.
`timescale 1ns/1ns
module mmd_decoder_tb_top;
  import mmd_pkg::*;
  logic clk, rstn, req, word, write, fetch, rflag, rvalid;
  mmd_kind_t kind;
  logic [15:0] addr, lo_a, hi_a, pc;
  logic [10:0] index;
  logic [7:0] rlo, rhi;
  logic [3:0] dly;
  logic ready, romless, prog, merr, ack, oword, owrite, ofetch;
  logic ext, fast, macro, gpr, pcld;
  logic [2:0] bank;
  mmd_target_t tgt;
  logic pa, pb, ready2, prog2, merr2, ack2;
  mmd_target_t tgt2;
  int n_mismatch = 0;
  int checked = 0;

  mmd_decoder mmd_decoder_i (.I_REF_CLK(clk), .I_RSTN(rstn),
    .I_MODE_SELECT_PIN_A(pa), .I_MODE_SELECT_PIN_B(pb),
    .I_TABLE_RELOCATE_FLAG(rflag), .I_REQ(req), .I_KIND(kind),
    .I_ADDR(addr), .I_INDEX(index), .I_WORD(word), .I_WRITE(write),
    .I_FETCH(fetch), .I_RVALID(rvalid), .I_RDATA_LO(rlo),
    .I_RDATA_HI(rhi), .O_READY(ready), .O_ROMLESS(romless),
    .O_PROG_MODE(prog), .O_MODE_ERR(merr), .O_ACK(ack), .O_TARGET(tgt),
    .O_LO_ADDR(lo_a), .O_HI_ADDR(hi_a), .O_WORD(oword),
    .O_WRITE(owrite), .O_FETCH(ofetch), .O_EXT_REQ(ext), .O_FAST(fast),
    .O_MACRO_AREA(macro), .O_GPR_AREA(gpr), .O_GPR_BANK(bank),
    .O_PC_LOAD(pcld), .O_PC(pc));

  // The programmable variant sees the same pins and requests.
  mmd_decoder #(.VARIANT(VAR_OTP48K)) mmd_decoder_otp_i (.I_REF_CLK(clk),
    .I_RSTN(rstn), .I_MODE_SELECT_PIN_A(pa), .I_MODE_SELECT_PIN_B(pb),
    .I_TABLE_RELOCATE_FLAG(rflag), .I_REQ(req), .I_KIND(kind),
    .I_ADDR(addr), .I_INDEX(index), .I_WORD(word), .I_WRITE(write),
    .I_FETCH(fetch), .I_RVALID(rvalid), .I_RDATA_LO(rlo),
    .I_RDATA_HI(rhi), .O_READY(ready2), .O_ROMLESS(),
    .O_PROG_MODE(prog2), .O_MODE_ERR(merr2), .O_ACK(ack2),
    .O_TARGET(tgt2), .O_LO_ADDR(), .O_HI_ADDR(), .O_WORD(), .O_WRITE(),
    .O_FETCH(), .O_EXT_REQ(), .O_FAST(), .O_MACRO_AREA(), .O_GPR_AREA(),
    .O_GPR_BANK(), .O_PC_LOAD(), .O_PC());

  mmd_core_model mmd_core_model_i (.i_clk(clk), .i_ack(ack),
    .i_ready(ready), .i_lo_addr(lo_a), .i_hi_addr(hi_a), .i_delay(dly),
    .o_rvalid(rvalid), .o_rdata_lo(rlo), .o_rdata_hi(rhi));

  function automatic logic [7:0] dat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task give_verdict;
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task step;
    @(posedge clk);
    #1;
  endtask

  // Leaves the request up so the next call runs back to back.
  task acc(input logic [15:0] a, input logic w, input mmd_target_t t,
           input logic [15:0] lo, input logic [2:0] f);
    req = 1'b1;
    kind = KIND_ACCESS;
    addr = a;
    word = w;
    write = a[0];
    fetch = ~w;
    step();
    chk("ack", 16'h0001, {15'h0000, ack});
    chk("lo_addr", lo, lo_a);
    chk("hi_addr", w ? lo + 16'h0001 : lo, hi_a);
    chk("flags", {13'h0000, w, a[0], ~w}, {13'h0000, oword, owrite, ofetch});
    chk("target", {13'h0000, t}, {13'h0000, tgt});
    chk("ext_req", {15'h0000, t == TGT_EXT}, {15'h0000, ext});
    chk("area", {13'h0000, f}, {13'h0000, fast, macro, gpr});
    chk("bank", {13'h0000, a[6:4]}, {13'h0000, bank});
  endtask

  task otp_acc(input logic [15:0] a, input mmd_target_t t);
    req = 1'b1;
    kind = KIND_ACCESS;
    addr = a;
    word = 1'b0;
    write = 1'b0;
    fetch = 1'b1;
    step();
    chk("otp_ack", 16'h0001, {15'h0000, ack2});
    chk("otp_target", {13'h0000, t}, {13'h0000, tgt2});
  endtask

  task idle;
    req = 1'b0;
    step();
    chk("ack_end", 16'h0000, {15'h0000, ack});
    chk("pcld_end", 16'h0000, {15'h0000, pcld});
  endtask

  task vec(input mmd_kind_t k, input logic [4:0] i, input logic fl,
           input logic [15:0] lo, input mmd_target_t t, input logic [3:0] d);
    int n;
    dly = d;
    rflag = fl;
    req = 1'b1;
    kind = k;
    index = {6'h00, i};
    step();
    req = 1'b0;
    chk("v_ack", 16'h0001, {15'h0000, ack});
    chk("v_busy", 16'h0000, {15'h0000, ready});
    chk("v_lo", lo, lo_a);
    chk("v_hi", lo + 16'h0001, hi_a);
    chk("v_target", {13'h0000, t}, {13'h0000, tgt});
    chk("v_ext", {15'h0000, t == TGT_EXT}, {15'h0000, ext});
    n = 0;
    while (pcld !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    chk("v_pcld", 16'h0001, {15'h0000, pcld});
    chk("v_pc", {dat(lo + 16'h0001), dat(lo)}, pc);
    chk("v_ready", 16'h0001, {15'h0000, ready});
  endtask

  task fc(input logic [10:0] i);
    req = 1'b1;
    kind = KIND_FCALL;
    index = i;
    step();
    chk("f_pcld", 16'h0001, {15'h0000, pcld});
    chk("f_ack", 16'h0000, {15'h0000, ack});
    chk("f_pc", 16'h0800 | {5'h00, i}, pc);
  endtask

  // Mode is caught at the fourth edge after release, ready at the fifth.
  task rel(input logic [2:0] m, input logic [2:0] o);
    rstn = 1'b1;
    repeat (4) step();
    chk("early_ready", 16'h0000, {15'h0000, ready});
    step();
    chk("ready", 16'h0001, {15'h0000, ready});
    chk("mode", {13'h0000, m}, {13'h0000, romless, prog, merr});
    chk("otp_mode", {13'h0000, o}, {13'h0000, ready2, prog2, merr2});
  endtask

  task hold_reset(input logic a, input logic b);
    req = 1'b0;
    rstn = 1'b0;
    pa = a;
    pb = b;
    repeat (2) step();
  endtask

  task t_reset;
    rel(3'b000, 3'b100);
  endtask

  task t_map;
    acc(16'h0000, 1'b0, TGT_ROM, 16'h0000, 3'b000);
    acc(16'h7fff, 1'b0, TGT_ROM, 16'h7fff, 3'b000);
    acc(16'h8000, 1'b0, TGT_EXT, 16'h8000, 3'b000);
    acc(16'hf6ff, 1'b0, TGT_EXT, 16'hf6ff, 3'b000);
    acc(16'hf700, 1'b0, TGT_PRAM, 16'hf700, 3'b000);
    acc(16'hfdff, 1'b0, TGT_PRAM, 16'hfdff, 3'b000);
    acc(16'hfe00, 1'b0, TGT_MRAM, 16'hfe00, 3'b100);
    acc(16'hfe05, 1'b0, TGT_MRAM, 16'hfe05, 3'b100);
    acc(16'hfe06, 1'b0, TGT_MRAM, 16'hfe06, 3'b110);
    acc(16'hfe25, 1'b0, TGT_MRAM, 16'hfe25, 3'b110);
    acc(16'hfe26, 1'b0, TGT_MRAM, 16'hfe26, 3'b100);
    acc(16'hfe7f, 1'b0, TGT_MRAM, 16'hfe7f, 3'b100);
    acc(16'hfe80, 1'b0, TGT_MRAM, 16'hfe80, 3'b101);
    acc(16'hfef5, 1'b0, TGT_MRAM, 16'hfef5, 3'b101);
    acc(16'hff00, 1'b0, TGT_SFR, 16'hff00, 3'b000);
    acc(16'hffd0, 1'b0, TGT_EXT, 16'hffd0, 3'b000);
    acc(16'hffff, 1'b0, TGT_SFR, 16'hffff, 3'b000);
    otp_acc(16'hbfff, TGT_ROM);
    otp_acc(16'hc000, TGT_EXT);
    idle();
  endtask

  task t_pair;
    acc(16'hfe20, 1'b1, TGT_MRAM, 16'hfe20, 3'b110);
    acc(16'hfe21, 1'b1, TGT_MRAM, 16'hfe20, 3'b110);
    acc(16'hfd00, 1'b1, TGT_PRAM, 16'hfd00, 3'b000);
    acc(16'hfd01, 1'b1, TGT_PRAM, 16'hfd01, 3'b000);
    acc(16'hfdff, 1'b1, TGT_PRAM, 16'hfefe, 3'b000);
    acc(16'h7ffe, 1'b1, TGT_ROM, 16'h7ffe, 3'b000);
    idle();
  endtask

  task t_vec;
    vec(KIND_VECTOR, 5'd0, 1'b0, 16'h0000, TGT_ROM, 4'h1);
    vec(KIND_VECTOR, 5'd1, 1'b0, 16'h0002, TGT_ROM, 4'h4);
    vec(KIND_VECTOR, 5'd18, 1'b0, 16'h0024, TGT_ROM, 4'h1);
    vec(KIND_VECTOR, 5'd30, 1'b0, 16'h003c, TGT_ROM, 4'h2);
    vec(KIND_VECTOR, 5'd31, 1'b0, 16'h003e, TGT_ROM, 4'h1);
    vec(KIND_VECTOR, 5'd1, 1'b1, 16'h8002, TGT_EXT, 4'h2);
    vec(KIND_VECTOR, 5'd18, 1'b1, 16'h8024, TGT_EXT, 4'h1);
    vec(KIND_VECTOR, 5'd31, 1'b1, 16'h803e, TGT_EXT, 4'h3);
    vec(KIND_VECTOR, 5'd0, 1'b1, 16'h0000, TGT_ROM, 4'h1);
    vec(KIND_TCALL, 5'd0, 1'b0, 16'h0040, TGT_ROM, 4'h1);
    vec(KIND_TCALL, 5'd31, 1'b0, 16'h007e, TGT_ROM, 4'h2);
    vec(KIND_TCALL, 5'd0, 1'b1, 16'h8040, TGT_EXT, 4'h1);
    vec(KIND_TCALL, 5'd31, 1'b1, 16'h807e, TGT_EXT, 4'h5);
    rflag = 1'b0;
  endtask

  task t_fcall;
    fc(11'h000);
    fc(11'h7ff);
    fc(11'h123);
    idle();
  endtask

  task t_mode;
    hold_reset(1'b1, 1'b1);
    rel(3'b100, 3'b101);
    acc(16'h0000, 1'b0, TGT_EXT, 16'h0000, 3'b000);
    chk("otp_rom", {13'h0000, TGT_ROM}, {13'h0000, tgt2});
    idle();
    hold_reset(1'b1, 1'b0);
    rel(3'b001, 3'b010);
    acc(16'h0000, 1'b0, TGT_ROM, 16'h0000, 3'b000);
    chk("otp_refuse", 16'h0000, {15'h0000, ack2});
    idle();
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    rstn = 1'b0;
    req = 1'b0;
    kind = KIND_ACCESS;
    addr = 16'h0000;
    index = 11'h000;
    word = 1'b0;
    write = 1'b0;
    fetch = 1'b0;
    rflag = 1'b0;
    pa = 1'b0;
    pb = 1'b0;
    dly = 4'h1;
    repeat (6) @(posedge clk);
    #1;
    t_reset();
    t_map();
    t_pair();
    t_vec();
    t_fcall();
    t_mode();
    give_verdict();
  end
endmodule
